// ### rtl/pdm_pkg.sv
// constants shared by the port d/e pin function mux
// Notes on behaviour
// - after reset d0/d1 are gpio; port d peripheral enable bit 0 hands d0 over
// - select bit 4 picks chip select 2 or second can transmit on d0
// - port d peripheral enable bit 1 hands d1 to its peripheral
// - select bit 5 picks chip select 3 output or second can receive on d1
// - every gpio pin has its own direction bit
// - chip selects 2 to 7 come decoded from the external memory interface
// - idle drive low floats chip selects 2 to 7 while the bus is idle
// - d2 to d5 reset as gpio inputs with pull-ups on
// - clearing port d pull-up bit n turns off the pull-up on pin n
// - second can receive keeps a pull-up governed by port d pull-up bit 1
// - e0/e1 reset to first serial port: transmit on e0, receive on e1
// - clearing port e pull-up bit 0 or 1 turns off that pin's pull-up
package pdm_pkg;
  localparam int unsigned PD_W            = 6;
  localparam int unsigned PE_W            = 2;
  localparam int unsigned SEL_W           = 8;
  localparam int unsigned SEL_D0_BIT      = 4;
  localparam int unsigned SEL_D1_BIT      = 5;
  localparam logic [5:0]  PD_PER_RST      = 6'h00;
  localparam logic [1:0]  PE_PER_RST      = 2'h3;
  localparam logic [5:0]  PD_PULLUP_RST   = 6'h3f;
  localparam logic [1:0]  PE_PULLUP_RST   = 2'h3;
  localparam logic [7:0]  SEL_RST         = 8'h00;
endpackage

// ### rtl/pdm_pin_cell.sv
// one muxed pin: gpio versus peripheral output, enable and pull-up
`timescale 1ns/1ps
module pdm_pin_cell (
  input  wire logic per_en_i,
  input  wire logic gpio_out_i,
  input  wire logic gpio_oe_i,
  input  wire logic per_out_i,
  input  wire logic per_oe_i,
  input  wire logic pullup_en_i,
  output logic      pad_out_o,
  output logic      pad_oe_o,
  output logic      pad_pu_o
);
  always_comb begin
    pad_out_o = per_en_i ? per_out_i : gpio_out_i;
    pad_oe_o  = per_en_i ? per_oe_i  : gpio_oe_i;
    pad_pu_o  = pullup_en_i & ~pad_oe_o;
  end
endmodule // pdm_pin_cell

// ### rtl/pdm_pin_mux.sv
// port d pins 0-5 and port e pins 0-1 function mux with registered pad outputs
`timescale 1ns/1ps
module pdm_pin_mux #(
  parameter int unsigned PD_W = pdm_pkg::PD_W,
  parameter int unsigned PE_W = pdm_pkg::PE_W
) (
  input  wire logic            clk_i,
  input  wire logic            rstn_i,
  // software configuration
  input  wire logic [PD_W-1:0] port_d_peripheral_enable_i,
  input  wire logic [PE_W-1:0] port_e_peripheral_enable_i,
  input  wire logic [7:0]      peripheral_function_select_i,
  input  wire logic [PD_W-1:0] port_d_pullup_enable_i,
  input  wire logic [PE_W-1:0] port_e_pullup_enable_i,
  input  wire logic            idle_drive_select_i,
  input  wire logic            config_load_i,
  // gpio data and direction
  input  wire logic [PD_W-1:0] port_d_gpio_out_i,
  input  wire logic [PD_W-1:0] port_d_gpio_dir_i,
  input  wire logic [PE_W-1:0] port_e_gpio_out_i,
  input  wire logic [PE_W-1:0] port_e_gpio_dir_i,
  output logic      [PD_W-1:0] port_d_gpio_in_o,
  output logic      [PE_W-1:0] port_e_gpio_in_o,
  // external memory interface chip selects 2..7, active low
  input  wire logic [5:0]      chip_select_n_i,
  input  wire logic            ext_bus_active_i,
  // second can and first serial port
  input  wire logic            second_can_transmit_i,
  output logic                 second_can_receive_o,
  input  wire logic            serial0_transmit_i,
  output logic                 serial0_receive_o,
  // pads
  input  wire logic [PD_W-1:0] port_d_pad_i,
  input  wire logic [PE_W-1:0] port_e_pad_i,
  output logic      [PD_W-1:0] port_d_pad_o,
  output logic      [PD_W-1:0] port_d_pad_oe_o,
  output logic      [PD_W-1:0] port_d_pad_pu_o,
  output logic      [PE_W-1:0] port_e_pad_o,
  output logic      [PE_W-1:0] port_e_pad_oe_o,
  output logic      [PE_W-1:0] port_e_pad_pu_o,
  output logic                 port_d_function_status_o
);
  // configuration registers, loaded by config_load_i
  logic [PD_W-1:0] d_per_r, d_per_nxt, d_pu_r, d_pu_nxt;
  logic [PE_W-1:0] e_per_r, e_per_nxt, e_pu_r, e_pu_nxt;
  logic [7:0]      sel_r, sel_nxt;
  logic            drv_r, drv_nxt;

  always_comb begin
    d_per_nxt = d_per_r;
    e_per_nxt = e_per_r;
    d_pu_nxt  = d_pu_r;
    e_pu_nxt  = e_pu_r;
    sel_nxt   = sel_r;
    drv_nxt   = drv_r;
    if (config_load_i) begin
      d_per_nxt = port_d_peripheral_enable_i;
      e_per_nxt = port_e_peripheral_enable_i;
      d_pu_nxt  = port_d_pullup_enable_i;
      e_pu_nxt  = port_e_pullup_enable_i;
      sel_nxt   = peripheral_function_select_i;
      drv_nxt   = idle_drive_select_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      d_per_r <= PD_W'(pdm_pkg::PD_PER_RST);
      e_per_r <= PE_W'(pdm_pkg::PE_PER_RST);
      d_pu_r  <= PD_W'(pdm_pkg::PD_PULLUP_RST);
      e_pu_r  <= PE_W'(pdm_pkg::PE_PULLUP_RST);
      sel_r   <= pdm_pkg::SEL_RST;
      drv_r   <= 1'b0;
    end else begin
      d_per_r <= d_per_nxt;
      e_per_r <= e_per_nxt;
      d_pu_r  <= d_pu_nxt;
      e_pu_r  <= e_pu_nxt;
      sel_r   <= sel_nxt;
      drv_r   <= drv_nxt;
    end
  end

  // peripheral side of each port d pin
  logic [PD_W-1:0] d_po, d_poe, d_out, d_oe, d_pu;
  logic            d0_can, d1_can, cs_drive;
  always_comb begin
    d0_can   = sel_r[pdm_pkg::SEL_D0_BIT];
    d1_can   = sel_r[pdm_pkg::SEL_D1_BIT];
    cs_drive = ext_bus_active_i | drv_r;
    d_po     = chip_select_n_i[PD_W-1:0];
    d_poe    = {PD_W{cs_drive}};
    if (d0_can) begin
      // can transmit is open drain: only drives low
      d_po[0]  = 1'b0;
      d_poe[0] = ~second_can_transmit_i;
    end
    if (d1_can) begin
      d_po[1]  = 1'b0;
      d_poe[1] = 1'b0;
    end
  end

  for (genvar i = 0; i < PD_W; i++) begin : g_pd
    pdm_pin_cell u_cell (
      .per_en_i    (d_per_r[i]),
      .gpio_out_i  (port_d_gpio_out_i[i]),
      .gpio_oe_i   (port_d_gpio_dir_i[i]),
      .per_out_i   (d_po[i]),
      .per_oe_i    (d_poe[i]),
      .pullup_en_i (d_pu_r[i]),
      .pad_out_o   (d_out[i]),
      .pad_oe_o    (d_oe[i]),
      .pad_pu_o    (d_pu[i])
    );
  end

  logic [PE_W-1:0] e_po, e_poe, e_out, e_oe, e_pu;
  always_comb begin
    e_po     = '0;
    e_poe    = '0;
    e_po[0]  = serial0_transmit_i;
    e_poe[0] = 1'b1;
  end

  for (genvar j = 0; j < PE_W; j++) begin : g_pe
    pdm_pin_cell u_cell (
      .per_en_i    (e_per_r[j]),
      .gpio_out_i  (port_e_gpio_out_i[j]),
      .gpio_oe_i   (port_e_gpio_dir_i[j]),
      .per_out_i   (e_po[j]),
      .per_oe_i    (e_poe[j]),
      .pullup_en_i (e_pu_r[j]),
      .pad_out_o   (e_out[j]),
      .pad_oe_o    (e_oe[j]),
      .pad_pu_o    (e_pu[j])
    );
  end

  // input routing: gpio sees its pin only in gpio mode, peripheral inputs idle high
  logic [PD_W-1:0] d_gin;
  logic [PE_W-1:0] e_gin;
  logic            can_rx, sci_rx;
  always_comb begin
    d_gin  = port_d_pad_i & ~d_per_r;
    e_gin  = port_e_pad_i & ~e_per_r;
    can_rx = (d_per_r[1] & d1_can) ? port_d_pad_i[1] : 1'b1;
    sci_rx = e_per_r[1] ? port_e_pad_i[1] : 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      port_d_pad_o             <= '0;
      port_d_pad_oe_o          <= '0;
      port_d_pad_pu_o          <= PD_W'(pdm_pkg::PD_PULLUP_RST);
      port_e_pad_o             <= '0;
      port_e_pad_oe_o          <= '0;
      port_e_pad_pu_o          <= PE_W'(pdm_pkg::PE_PULLUP_RST);
      port_d_gpio_in_o         <= '0;
      port_e_gpio_in_o         <= '0;
      second_can_receive_o     <= 1'b1;
      serial0_receive_o        <= 1'b1;
      port_d_function_status_o <= 1'b0;
    end else begin
      port_d_pad_o             <= d_out;
      port_d_pad_oe_o          <= d_oe;
      port_d_pad_pu_o          <= d_pu;
      port_e_pad_o             <= e_out;
      port_e_pad_oe_o          <= e_oe;
      port_e_pad_pu_o          <= e_pu;
      port_d_gpio_in_o         <= d_gin;
      port_e_gpio_in_o         <= e_gin;
      second_can_receive_o     <= can_rx;
      serial0_receive_o        <= sci_rx;
      port_d_function_status_o <= |d_per_r;
    end
  end

  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  d0_gpio_follow_a: assert property (
    !d_per_r[0] |=> port_d_pad_o[0] == $past(port_d_gpio_out_i[0]))
    else $error("d0 in gpio mode does not follow gpio data");
  d0_can_sel_a: assert property (
    d_per_r[0] && d0_can |=> port_d_pad_o[0] == 1'b0)
    else $error("d0 can transmit drives other than low");
  d0_cs_sel_a: assert property (
    d_per_r[0] && !d0_can |=> port_d_pad_o[0] == $past(chip_select_n_i[0]))
    else $error("d0 does not carry chip select 2");
  d1_rx_route_a: assert property (
    d_per_r[1] && d1_can |=>
      !port_d_pad_oe_o[1] && second_can_receive_o == $past(port_d_pad_i[1]))
    else $error("d1 can receive routing wrong");
  gpio_dir_a: assert property (
    !d_per_r[3] |=> port_d_pad_oe_o[3] == $past(port_d_gpio_dir_i[3]))
    else $error("gpio direction not honoured");
  cs_float_a: assert property (
    d_per_r[2] && !drv_r && !ext_bus_active_i |=> !port_d_pad_oe_o[2])
    else $error("chip select driven while bus idle");
  reset_cfg_a: assert property (
    $rose(rstn_i) |-> d_per_r == '0 && d_pu_r == '1 && e_per_r == '1)
    else $error("reset configuration wrong");
  pullup_off_a: assert property (
    !d_pu_r[0] |=> !port_d_pad_pu_o[0])
    else $error("port d pull-up still on");
  e_pullup_off_a: assert property (
    !e_pu_r[1] |=> !port_e_pad_pu_o[1])
    else $error("port e pull-up still on");
  sci_tx_a: assert property (
    e_per_r[0] |=> port_e_pad_oe_o[0] && port_e_pad_o[0] == $past(serial0_transmit_i))
    else $error("serial transmit not on e0");
  d1_cs_drive_a: assert property (
    d_per_r[1] && !d1_can && drv_r |=> port_d_pad_oe_o[1])
    else $error("d1 chip select not driven");
  gpio_in_a: assert property (
    d_per_r[4] |=> !port_d_gpio_in_o[4])
    else $error("gpio input leaks in peripheral mode");
  can_rx_pullup_a: assert property (
    d_per_r[1] && d1_can |=> port_d_pad_pu_o[1] == $past(d_pu_r[1]))
    else $error("can receive pull-up not under its enable bit");
  sci_rx_route_a: assert property (
    e_per_r[1] |=> !port_e_pad_oe_o[1] && serial0_receive_o == $past(port_e_pad_i[1]))
    else $error("serial receive not taken from e1");
  gpio_pullup_a: assert property (
    !d_per_r[5] && !port_d_gpio_dir_i[5] |=> port_d_pad_pu_o[5] == $past(d_pu_r[5]))
    else $error("gpio input pull-up does not follow its enable");
  cs_idle_drive_a: assert property (
    d_per_r[5] && drv_r |=>
      port_d_pad_oe_o[5] && port_d_pad_o[5] == $past(chip_select_n_i[5]))
    else $error("chip select 7 not driven with idle drive set");
  e_gpio_in_a: assert property (
    e_per_r[0] |=> !port_e_gpio_in_o[0])
    else $error("port e gpio input leaks in peripheral mode");

  can_tx_c: cover property (d_per_r[0] && d0_can);
  can_rx_c: cover property (d_per_r[1] && d1_can);
  cs_idle_c: cover property (d_per_r[2] && !cs_drive);
  sci_gpio_c: cover property (!e_per_r[0] && port_e_gpio_dir_i[0]);
  cs_held_c: cover property (d_per_r[5] && drv_r && !ext_bus_active_i);
endmodule // pdm_pin_mux

// ### tb/pdm_pad_model.sv
// pad level model: pin driver first, then outside driver, pull-up, else a floating level
`timescale 1ns/1ps
module pdm_pad_model #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] pad_o_i,
  input  wire logic [W-1:0] pad_oe_i,
  input  wire logic [W-1:0] pad_pu_i,
  input  wire logic [W-1:0] ext_en_i,
  input  wire logic [W-1:0] ext_val_i,
  output logic      [W-1:0] level_o
);
  logic [W-1:0] float_r = '0;
  // a pin nobody drives and nothing pulls up changes every cycle
  always_ff @(posedge clk_i) begin
    float_r <= ~float_r;
  end
  always_comb begin
    for (int k = 0; k < W; k++) begin
      level_o[k] = pad_oe_i[k] ? pad_o_i[k] : ext_en_i[k] ? ext_val_i[k] :
                   pad_pu_i[k] ? 1'b1 : float_r[k];
    end
  end
endmodule // pdm_pad_model

// ### tb/port_d_e_pin_function_mux_bench.sv
// self-checking bench of the port d/e pin function mux
`timescale 1ns/1ps
module port_d_e_pin_function_mux_bench;
  logic       clk_i = 1'b0, rstn_i = 1'b0, idle = 1'b0, ld = 1'b0, act = 1'b0;
  logic       cantx = 1'b1, stx = 1'b1, crx, srx, st;
  logic [7:0] sel = 8'h00;
  logic [5:0] dper = 6'h00, dpu = 6'h3f, dout = 6'h00, ddir = 6'h00, cs = 6'h3f;
  logic [5:0] dxe = 6'h00, dxv = 6'h00, dgi, dpi, dpo, doe, dpuo;
  logic [1:0] eper = 2'h3, epu = 2'h3, eout = 2'h0, edir = 2'h0, exe = 2'h0, exv = 2'h0;
  logic [1:0] egi, epi, epo, eoe, epuo;
  int         errors = 0, num_checks = 0;
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  pdm_pin_mux #(.PD_W(pdm_pkg::PD_W), .PE_W(pdm_pkg::PE_W)) pdm_pin_mux_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .port_d_peripheral_enable_i(dper),
    .port_e_peripheral_enable_i(eper), .peripheral_function_select_i(sel),
    .port_d_pullup_enable_i(dpu), .port_e_pullup_enable_i(epu), .idle_drive_select_i(idle),
    .config_load_i(ld), .port_d_gpio_out_i(dout), .port_d_gpio_dir_i(ddir),
    .port_e_gpio_out_i(eout), .port_e_gpio_dir_i(edir), .port_d_gpio_in_o(dgi),
    .port_e_gpio_in_o(egi), .chip_select_n_i(cs), .ext_bus_active_i(act),
    .second_can_transmit_i(cantx), .second_can_receive_o(crx), .serial0_transmit_i(stx),
    .serial0_receive_o(srx), .port_d_pad_i(dpi), .port_e_pad_i(epi), .port_d_pad_o(dpo),
    .port_d_pad_oe_o(doe), .port_d_pad_pu_o(dpuo), .port_e_pad_o(epo),
    .port_e_pad_oe_o(eoe), .port_e_pad_pu_o(epuo), .port_d_function_status_o(st));
  pdm_pad_model #(.W(6)) pdm_pad_model_d_inst (.clk_i(clk_i), .pad_o_i(dpo), .pad_oe_i(doe),
    .pad_pu_i(dpuo), .ext_en_i(dxe), .ext_val_i(dxv), .level_o(dpi));
  pdm_pad_model #(.W(2)) pdm_pad_model_e_inst (.clk_i(clk_i), .pad_o_i(epo), .pad_oe_i(eoe),
    .pad_pu_i(epuo), .ext_en_i(exe), .ext_val_i(exv), .level_o(epi));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic cfg(input logic [5:0] dp, input logic [1:0] ep, input logic [7:0] s,
                     input logic [5:0] du, input logic [1:0] eu, input logic id);
    @(posedge clk_i);
    {dper, eper, sel, dpu, epu, idle, ld} <= {dp, ep, s, du, eu, id, 1'b1};
    @(posedge clk_i);
    ld <= 1'b0;
    step(3);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_reset();
    chk(doe, 16'h0000);
    chk(dpuo, 16'h003f);
    chk(dgi, 16'h003f);
    chk(egi, 16'h0000);
    chk(st, 16'h0000);
    chk({eoe[0], epo[0]}, 16'h0003);
    @(posedge clk_i);
    {exe, exv} <= {2'h2, 2'h0};
    step(3);
    chk({eoe[1], srx}, 16'h0000);
  endtask
  task automatic t_gpio();
    cfg(6'h00, 2'h0, 8'h00, 6'h3f, 2'h3, 1'b0);
    @(posedge clk_i);
    {ddir, dout, edir, eout, exe} <= {6'h15, 6'h11, 2'h1, 2'h1, 2'h0};
    step(3);
    chk(doe, 16'h0015);
    chk(dpo & 6'h15, 16'h0011);
    chk(dpuo, 16'h002a);
    chk(dgi, 16'h003b);
    chk({eoe, epo[0], egi, srx}, 16'h001f);
    @(posedge clk_i);
    {ddir, edir} <= {6'h00, 2'h0};
    cfg(6'h00, 2'h0, 8'h00, 6'h3e, 2'h2, 1'b0);
    chk({dpuo, epuo}, 16'h00fa);
    chk(dgi[5:1], 16'h001f);
  endtask
  task automatic t_d0();
    cfg(6'h01, 2'h0, 8'h00, 6'h3f, 2'h3, 1'b0);
    @(posedge clk_i);
    {act, cs} <= {1'b1, 6'h3e};
    step(3);
    chk({doe, dpo[0], dgi[0], st}, 16'h0009);
    @(posedge clk_i);
    cs <= 6'h3f;
    step(3);
    chk(dpo[0], 16'h0001);
    cfg(6'h01, 2'h0, 8'h10, 6'h3f, 2'h3, 1'b0);
    @(posedge clk_i);
    cantx <= 1'b0;
    step(3);
    chk({doe, dpo[0]}, 16'h0002);
    @(posedge clk_i);
    cantx <= 1'b1;
    step(3);
    chk(doe, 16'h0000);
  endtask
  task automatic t_d1();
    cfg(6'h02, 2'h0, 8'h00, 6'h3f, 2'h3, 1'b0);
    @(posedge clk_i);
    cs <= 6'h3d;
    step(3);
    chk({doe, dpo[1], crx}, 16'h0009);
    cfg(6'h02, 2'h0, 8'h20, 6'h3f, 2'h3, 1'b0);
    @(posedge clk_i);
    {dxe, dxv} <= {6'h02, 6'h00};
    step(3);
    chk({doe, crx}, 16'h0000);
    @(posedge clk_i);
    dxe <= 6'h00;
    step(3);
    chk({dpuo[1], crx}, 16'h0003);
    cfg(6'h02, 2'h0, 8'h20, 6'h3d, 2'h3, 1'b0);
    chk(dpuo[1], 16'h0000);
  endtask
  task automatic t_idle();
    cfg(6'h3f, 2'h0, 8'h00, 6'h3f, 2'h3, 1'b0);
    @(posedge clk_i);
    {act, cs} <= {1'b0, 6'h2a};
    step(3);
    chk(doe, 16'h0000);
    @(posedge clk_i);
    act <= 1'b1;
    step(3);
    chk({doe, dpo}, {6'h3f, 6'h2a});
    @(posedge clk_i);
    act <= 1'b0;
    cfg(6'h3f, 2'h0, 8'h00, 6'h3f, 2'h3, 1'b1);
    chk({doe, dpo}, {6'h3f, 6'h2a});
  endtask
  // reset in mid-run must drop the loaded configuration
  task automatic t_rerst();
    @(posedge clk_i);
    rstn_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk({doe, dpo, st}, 16'h0000);
    chk({dpuo, epuo, eoe, crx, srx}, {6'h3f, 2'h3, 2'h0, 2'h3});
    @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk({doe, st}, 16'h0000);
    chk({dpuo, dgi}, {6'h3f, 6'h3f});
    chk({eoe, epo, egi, srx}, {2'h1, 2'h1, 2'h0, 1'b1});
  endtask
  initial begin
    #200000;
    errors++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    step(3);
    t_reset();
    t_gpio();
    t_d0();
    t_d1();
    t_idle();
    t_rerst();
    conclude();
  end
endmodule // port_d_e_pin_function_mux_bench
